//--- pkg/fom_defines.svh
// Constants of the fieldbus object mapper
`ifndef FOM_DEFINES_SVH
`define FOM_DEFINES_SVH
`define FOM_INDEX_OFFSET     16'h2001
`define FOM_INDEX_TOP        16'h5FFF
`define FOM_REG_TOP          14'h3FFF
`define FOM_REG_RATED_V      14'h0079
`define FOM_REG_STATE        14'h01F9
`define FOM_REG_MEAS_V       14'h01FB
`define FOM_REG_MEAS_I       14'h01FC
`define FOM_REG_MEAS_P       14'h01FD
`define FOM_BIT_MASTER       6
`define FOM_BIT_OUTPUT_ON    7
`define FOM_BIT_CC           10
`define FOM_BIT_SINK         12
`define FOM_FULL_SCALE       16'hCCCC
`define FOM_SLOTS            8
`define FOM_FRAME_BYTES      5'h12
`endif

//--- pkg/fom_pkg.sv
// Types of the fieldbus object mapper
package fom_pkg;
  typedef enum logic [1:0] {FOM_IDLE, FOM_SEND} fom_frame_e;
  typedef logic [13:0] fom_reg_t;
endpackage

//--- src/fom_index_decode.sv
// Object index to register address translation
`timescale 1ns/1ps
`include "fom_defines.svh"
module fom_index_decode (
  // Index in
  input  wire logic [15:0]     obj_index,
  // Register out
  output fom_pkg::fom_reg_t    reg_addr,
  output logic                 reg_valid
);
  logic [15:0] diff;
  always_comb begin
    diff      = obj_index - `FOM_INDEX_OFFSET;
    // Window check: first index is register 0, top index register 16382
    reg_valid = (obj_index >= `FOM_INDEX_OFFSET) &&
                (obj_index <= `FOM_INDEX_TOP);
    reg_addr  = reg_valid ? diff[13:0] : 14'h0000;
  end
endmodule

//--- src/fom_mapper.sv
// Fieldbus object mapper: acyclic reads and cyclic process image
`timescale 1ns/1ps
`include "fom_defines.svh"
module fom_mapper #(
  parameter int VAL_W = 16
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Device state from the power stage
  input  wire logic [31:0]       rated_voltage_in,
  input  wire logic              master_role_in,
  input  wire logic              output_on_in,
  input  wire logic              constant_current_regulation_in,
  input  wire logic              sink_mode_in,
  input  wire logic [31:0]       state_other_in,
  input  wire logic [VAL_W-1:0]  measured_voltage_in,
  input  wire logic [VAL_W-1:0]  measured_current_in,
  input  wire logic [VAL_W-1:0]  measured_power_in,
  // Acyclic object read
  input  wire logic              rd_req,
  input  wire logic [15:0]       rd_index,
  output logic                   rd_ack,
  output logic                   rd_err,
  output logic [31:0]            rd_data,
  // Cyclic process image
  input  wire logic              cyc_start,
  output logic                   cyc_valid,
  output logic [7:0]             cyc_byte,
  output logic                   cyc_last
);
  fom_pkg::fom_reg_t  dec_addr;
  logic               dec_valid;

  fom_index_decode u_dec (
    .obj_index (rd_index),
    .reg_addr  (dec_addr),
    .reg_valid (dec_valid)
  );

  // Register file, sampled every cycle
  // Status group: nominal float and the assembled device status word
  logic [31:0]       rated_reg;
  logic [31:0]       rated_next;
  logic [31:0]       state_reg;
  logic [31:0]       state_next;
  // Value group: actual values, held as unsigned magnitudes
  logic [VAL_W-1:0]  volt_reg;
  logic [VAL_W-1:0]  volt_next;
  logic [VAL_W-1:0]  curr_reg;
  logic [VAL_W-1:0]  curr_next;
  logic [VAL_W-1:0]  pwr_reg;
  logic [VAL_W-1:0]  pwr_next;

  function automatic logic [VAL_W-1:0] fom_clip(input logic [VAL_W-1:0] v);
    // Values beyond full scale are not defined; hold them at 100 %
    fom_clip = (v > VAL_W'(`FOM_FULL_SCALE)) ? VAL_W'(`FOM_FULL_SCALE) : v;
  endfunction

  // Flags from the power stage replace the matching bits of the other status
  function automatic logic [31:0] fom_status(input logic [31:0] other,
                                             input logic        master,
                                             input logic        on,
                                             input logic        cc,
                                             input logic        sink);
    logic [31:0] w;
    w                     = other;
    w[`FOM_BIT_MASTER]    = master;
    w[`FOM_BIT_OUTPUT_ON] = on;
    w[`FOM_BIT_CC]        = cc;
    w[`FOM_BIT_SINK]      = sink;
    fom_status = w;
  endfunction

  always_comb begin
    rated_next = rated_voltage_in;
    state_next = fom_status(state_other_in, master_role_in, output_on_in,
                            constant_current_regulation_in, sink_mode_in);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rated_reg <= 32'h00000000;
      state_reg <= 32'h00000000;
    end else begin
      rated_reg <= rated_next;
      state_reg <= state_next;
    end
  end

  always_comb begin
    volt_next = fom_clip(measured_voltage_in);
    // Sign is never stored; the master reapplies it from the sink bit
    curr_next = fom_clip(measured_current_in);
    pwr_next  = fom_clip(measured_power_in);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      volt_reg <= '0;
      curr_reg <= '0;
      pwr_reg  <= '0;
    end else begin
      volt_reg <= volt_next;
      curr_reg <= curr_next;
      pwr_reg  <= pwr_next;
    end
  end

  // Acyclic read answer, one cycle after the request
  logic        ack_reg;
  logic        ack_next;
  logic        err_reg;
  logic        err_next;
  logic [31:0] data_reg;
  logic [31:0] data_next;
  logic        range_err;
  logic        map_err;

  // Only five registers sit behind this block; every other one is refused
  function automatic logic fom_is_mapped(input fom_pkg::fom_reg_t a);
    case (a)
      `FOM_REG_RATED_V,
      `FOM_REG_STATE,
      `FOM_REG_MEAS_V,
      `FOM_REG_MEAS_I,
      `FOM_REG_MEAS_P: fom_is_mapped = 1'b1;
      default:         fom_is_mapped = 1'b0;
    endcase
  endfunction

  always_comb begin
    range_err = rd_req && !dec_valid;
    map_err   = rd_req && dec_valid && !fom_is_mapped(dec_addr);
    ack_next  = rd_req;
    err_next  = range_err || map_err;
  end

  always_comb begin
    data_next = 32'h00000000;
    // A refused read returns zero so a stale word never leaks out
    if (rd_req && dec_valid && fom_is_mapped(dec_addr)) begin
      case (dec_addr)
        `FOM_REG_RATED_V: data_next = rated_reg;
        `FOM_REG_STATE:   data_next = state_reg;
        `FOM_REG_MEAS_V:  data_next = 32'(volt_reg);
        `FOM_REG_MEAS_I:  data_next = 32'(curr_reg);
        `FOM_REG_MEAS_P:  data_next = 32'(pwr_reg);
        default:          data_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
    end else begin
      ack_reg <= ack_next;
      err_reg <= err_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= 32'h00000000;
    end else begin
      data_reg <= data_next;
    end
  end

  assign rd_ack  = ack_reg;
  assign rd_err  = err_reg;
  assign rd_data = data_reg;

  // Cyclic frame: a snapshot is taken at start so slots stay coherent
  localparam logic [4:0] LAST_POS = `FOM_FRAME_BYTES - 5'h01;

  // Frame control group
  fom_pkg::fom_frame_e  fsm_reg;
  fom_pkg::fom_frame_e  fsm_next;
  logic [4:0]           pos_reg;
  logic [4:0]           pos_next;
  logic [31:0]          snap_state_reg;
  logic [31:0]          snap_state_next;
  logic [15:0]          snap_volt_reg;
  logic [15:0]          snap_volt_next;
  logic [15:0]          snap_curr_reg;
  logic [15:0]          snap_curr_next;
  logic [15:0]          snap_pwr_reg;
  logic [15:0]          snap_pwr_next;
  // Byte output group
  logic [7:0]           byte_reg;
  logic [7:0]           byte_next;
  logic                 valid_reg;
  logic                 valid_next;
  logic                 last_reg;
  logic                 last_next;

  // Bytes 0-9 hold slots 1-4, big end first; slots 5-8 read zero
  function automatic logic [7:0] fom_pick(input logic [79:0] s, input logic [4:0] p);
    logic [7:0] b;
    case (p)
      5'h00:   b = s[79:72];
      5'h01:   b = s[71:64];
      5'h02:   b = s[63:56];
      5'h03:   b = s[55:48];
      5'h04:   b = s[47:40];
      5'h05:   b = s[39:32];
      5'h06:   b = s[31:24];
      5'h07:   b = s[23:16];
      5'h08:   b = s[15:8];
      5'h09:   b = s[7:0];
      default: b = 8'h00;
    endcase
    fom_pick = b;
  endfunction

  always_comb begin
    fsm_next        = fsm_reg;
    pos_next        = pos_reg;
    snap_state_next = snap_state_reg;
    snap_volt_next  = snap_volt_reg;
    snap_curr_next  = snap_curr_reg;
    snap_pwr_next   = snap_pwr_reg;
    case (fsm_reg)
      fom_pkg::FOM_IDLE: begin
        // A start is only looked at here, so a frame never restarts midway
        if (cyc_start) begin
          snap_state_next = state_reg;
          snap_volt_next  = volt_reg[15:0];
          snap_curr_next  = curr_reg[15:0];
          snap_pwr_next   = pwr_reg[15:0];
          pos_next        = 5'h00;
          fsm_next        = fom_pkg::FOM_SEND;
        end
      end
      fom_pkg::FOM_SEND: begin
        pos_next = pos_reg + 5'h01;
        if (pos_reg == LAST_POS) begin
          fsm_next = fom_pkg::FOM_IDLE;
        end
      end
      default: fsm_next = fom_pkg::FOM_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fsm_reg        <= fom_pkg::FOM_IDLE;
      pos_reg        <= 5'h00;
      snap_state_reg <= 32'h00000000;
      snap_volt_reg  <= 16'h0000;
      snap_curr_reg  <= 16'h0000;
      snap_pwr_reg   <= 16'h0000;
    end else begin
      fsm_reg        <= fsm_next;
      pos_reg        <= pos_next;
      snap_state_reg <= snap_state_next;
      snap_volt_reg  <= snap_volt_next;
      snap_curr_reg  <= snap_curr_next;
      snap_pwr_reg   <= snap_pwr_next;
    end
  end

  // Registered bytes cost one cycle of latency but keep the outputs glitch free
  always_comb begin
    byte_next  = 8'h00;
    valid_next = 1'b0;
    last_next  = 1'b0;
    if (fsm_reg == fom_pkg::FOM_SEND) begin
      byte_next  = fom_pick({snap_state_reg, snap_volt_reg, snap_curr_reg, snap_pwr_reg},
                            pos_reg);
      valid_next = 1'b1;
      last_next  = (pos_reg == LAST_POS);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_reg  <= 8'h00;
      valid_reg <= 1'b0;
      last_reg  <= 1'b0;
    end else begin
      byte_reg  <= byte_next;
      valid_reg <= valid_next;
      last_reg  <= last_next;
    end
  end

  assign cyc_valid = valid_reg;
  assign cyc_byte  = byte_reg;
  assign cyc_last  = last_reg;
endmodule

//--- verification/fom_checker.sv
// Port assertions for the object mapper
`timescale 1ns/1ps
module fom_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_n,
  // Acyclic read
  input wire logic        rd_req,
  input wire logic [15:0] rd_index,
  input wire logic        rd_ack,
  input wire logic        rd_err,
  input wire logic [31:0] rd_data,
  // Cyclic image
  input wire logic        cyc_start,
  input wire logic        cyc_valid,
  input wire logic [7:0]  cyc_byte,
  input wire logic        cyc_last
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_mid; cyc_valid && !cyc_last; endsequence
  sequence s_body; s_mid[*8] ##1 s_mid[*8] ##1 s_mid ##1 (cyc_valid && cyc_last); endsequence
  property p_ack; rd_req |=> rd_ack; endproperty
  property p_idle; !rd_req |=> !rd_ack; endproperty
  property p_low; rd_req && rd_index < 16'h2001 |=> rd_err; endproperty
  property p_high; rd_req && rd_index > 16'h5FFF |=> rd_err; endproperty
  property p_zero; rd_ack && rd_err |-> rd_data == 32'h0; endproperty
  property p_state; rd_req && rd_index == 16'h21FA |=> !rd_err; endproperty
  property p_frame; $rose(cyc_valid) |-> s_body; endproperty
  property p_lead; $rose(cyc_valid) |-> $past(cyc_start, 2); endproperty
  property p_tail; $rose(cyc_valid) |-> ##10 (cyc_byte == 8'h00)[*8]; endproperty
  a_ack: assert property (p_ack) else $error("read not answered");
  a_idle: assert property (p_idle) else $error("answer without read");
  a_low: assert property (p_low) else $error("low index accepted");
  a_high: assert property (p_high) else $error("high index accepted");
  a_zero: assert property (p_zero) else $error("error read has data");
  a_state: assert property (p_state) else $error("status read refused");
  a_frame: assert property (p_frame) else $error("frame length wrong");
  a_lead: assert property (p_lead) else $error("frame without start");
  a_tail: assert property (p_tail) else $error("unused slot not zero");
endmodule
bind fom_mapper fom_checker u_chk (.clk, .rst_n, .rd_req, .rd_index, .rd_ack, .rd_err,
  .rd_data, .cyc_start, .cyc_valid, .cyc_byte, .cyc_last);

//--- verification/fom_master.sv
// Fieldbus master model that collects the cyclic image
`timescale 1ns/1ps
module fom_master (
  // Cyclic image in
  input wire logic           clk,
  input wire logic           cyc_valid,
  input wire logic [7:0]     cyc_byte,
  input wire logic           cyc_last,
  // Decoded view
  output logic [143:0]       image,
  output logic signed [31:0] cur_signed
);
  logic [143:0] shift = '0;
  // Bytes arrive most significant first, so each one enters at the bottom
  always @(posedge clk) begin
    if (cyc_valid) shift <= {shift[135:0], cyc_byte};
    if (cyc_valid && cyc_last) image <= {shift[135:0], cyc_byte};
  end
  // Magnitude only on the wire, so the sink flag restores the sign
  assign cur_signed = image[124] ? -{16'h0, image[95:80]} : {16'h0, image[95:80]};
endmodule

//--- verification/tb_fieldbus_object_mapper.sv
// Self-checking bench of the object mapper
`timescale 1ns/1ps
module tb_fieldbus_object_mapper;
  logic clk = 0, rst_n = 0, rd_req = 0, cyc_start = 0;
  logic mst = 0, on = 0, cc = 0, snk = 0;
  logic [15:0] rd_index = '0, v_in = '0, i_in = '0, p_in = '0;
  logic [31:0] rv_in = 32'h4379_0000, oth = 32'hA5A5_1234;
  logic rd_ack, rd_err, cyc_valid, cyc_last;
  logic [31:0] rd_data;
  logic [7:0] cyc_byte;
  logic [143:0] image;
  logic signed [31:0] cur_signed;
  int error_cnt = 0, total_checks = 0;
  fom_mapper uut (.clk(clk), .rst_n(rst_n), .rated_voltage_in(rv_in), .master_role_in(mst),
    .output_on_in(on), .constant_current_regulation_in(cc), .sink_mode_in(snk),
    .state_other_in(oth), .measured_voltage_in(v_in), .measured_current_in(i_in),
    .measured_power_in(p_in), .rd_req(rd_req), .rd_index(rd_index), .rd_ack(rd_ack),
    .rd_err(rd_err), .rd_data(rd_data), .cyc_start(cyc_start), .cyc_valid(cyc_valid),
    .cyc_byte(cyc_byte), .cyc_last(cyc_last));
  fom_master u_mst (.clk(clk), .cyc_valid(cyc_valid), .cyc_byte(cyc_byte),
    .cyc_last(cyc_last), .image(image), .cur_signed(cur_signed));
  function automatic logic [31:0] st_exp();
    return {oth[31:13], snk, oth[11], cc, oth[9:8], on, mst, oth[5:0]};
  endfunction
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic set(logic [3:0] b, logic [15:0] v, logic [15:0] i, logic [15:0] p);
    {mst, on, cc, snk} = b;
    v_in = v;
    i_in = i;
    p_in = p;
    repeat (2) @(posedge clk);
    #1;
  endtask
  // Request stays up between calls, so reads run back to back
  task automatic rd(logic [15:0] idx, logic err, logic [31:0] exp);
    rd_req = 1;
    rd_index = idx;
    @(posedge clk);
    #1;
    chk(rd_ack, 1);
    chk(rd_err, err);
    chk(rd_data, exp);
  endtask
  // Drop the request and let one edge pass before anyone raises it again
  task automatic rd_end();
    rd_req = 0;
    @(posedge clk);
    #1;
    chk(rd_ack, 0);
  endtask
  task automatic t_regs();
    set(4'b1110, 16'h263A, 16'h0C9B, 16'hFFFF);
    rd(16'h207A, 0, rv_in);
    rd(16'h21FA, 0, st_exp());
    rd(16'h21FC, 0, 32'h263A);
    rd(16'h21FD, 0, 32'h0C9B);
    rd(16'h21FE, 0, 32'hCCCC);
    rd_end();
    $display("register reads done");
  endtask
  task automatic t_range();
    rd(16'h2000, 1, 0);
    rd(16'h2001, 1, 0);
    rd(16'h5FFF, 1, 0);
    rd(16'h6000, 1, 0);
    rd(16'h21FA, 0, st_exp());
    rd_end();
    $display("index range done");
  endtask
  task automatic t_frame(logic [3:0] b);
    logic [143:0] e;
    set(b, 16'h263A, 16'h0C9B, 16'h0925);
    e = {st_exp(), v_in, i_in, p_in, 64'h0};
    cyc_start = 1;
    @(posedge clk);
    #1;
    cyc_start = 0;
    for (int k = 0; k < 18; k++) begin
      @(posedge clk);
      #1;
      cyc_start = (k == 4);
      chk(cyc_valid, 1);
      chk(cyc_byte, e[143-8*k -: 8]);
      chk(cyc_last, k == 17);
    end
    repeat (3) begin
      @(posedge clk);
      #1;
      chk(cyc_valid, 0);
    end
    chk(image[143:112], st_exp());
    chk(cur_signed, b[0] ? -32'(i_in) : 32'(i_in));
    $display("cyclic frame done");
  endtask
  task automatic stop_test();
    $display("checks %0d, mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    forever #5 clk = ~clk;
  end
  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rst_n = 1;
    t_regs();
    t_range();
    t_frame(4'b1110);
    t_frame(4'b0001);
    stop_test();
  end
endmodule
